// *** bench/tsa_ctl_model.sv ***
`timescale 1ns/10ps
module tsa_ctl_model (
	output logic       sclk_out, // Control shift clock
	output logic       cs_n_out, // Chip select, active low
	output logic       dat_out,  // Serial data
	output logic [1:0] ch_out    // Channel number
);
	initial {sclk_out, cs_n_out, dat_out, ch_out} = 5'h08;
	// 20 ns phases leave room for the pin synchronisers
	// Calls start on a system clock edge, so every pin moves by non-blocking update
	// An over-long word wraps round the same eight bits rather than shifting unknowns
	task automatic load(input logic [1:0] ch, input logic [7:0] w, input int nb);
		ch_out <= ch;
		cs_n_out <= 1'b0;
		for (int i = 0; i < nb; i++) begin
			#20 dat_out <= w[3'(7 - i)];
			#20 sclk_out <= 1'b1;
			#20 sclk_out <= 1'b0;
		end
		#20 cs_n_out <= 1'b1;
		#20 dat_out <= ~dat_out; // Released lines must not keep their value
		ch_out <= ~ch;
	endtask : load
endmodule : tsa_ctl_model

// *** bench/tsa_monitor.sv ***
`timescale 1ns/10ps
module tsa_monitor (
	input wire logic       sys_rst_in,                // Reset
	input wire logic       tx_bit_clock_in,           // Transmit bit clock
	input wire logic       rx_bit_clock_in,           // Receive bit clock
	input wire logic       tx_frame_start_in,         // Transmit frame start
	input wire logic       rx_frame_start_in,         // Receive frame start
	input wire logic [3:0] tx_slot_pulse_outputs_out, // Transmit pulses
	input wire logic [3:0] rx_slot_pulse_outputs_out, // Receive pulses
	input wire logic       tx_slot_active_n_out,      // Indicator drive value
	input wire logic       tx_slot_active_n_oe_out    // Indicator enable
);
	logic [8:0] tx_cnt_r;
	logic [8:0] rx_cnt_r;
	logic       tx_fs_r;
	logic       rx_fs_r;
	// Bit position since frame start; parks so a stale count never matches
	always_ff @(negedge tx_bit_clock_in) begin
		tx_fs_r  <= tx_frame_start_in;
		tx_cnt_r <= sys_rst_in ? 9'h1ff : (tx_frame_start_in && !tx_fs_r) ? 9'h0
			: tx_cnt_r + 9'(tx_cnt_r != 9'h1ff);
	end
	// Same position tracking on the receive clock
	always_ff @(negedge rx_bit_clock_in) begin
		rx_fs_r  <= rx_frame_start_in;
		rx_cnt_r <= sys_rst_in ? 9'h1ff : (rx_frame_start_in && !rx_fs_r) ? 9'h0
			: rx_cnt_r + 9'(rx_cnt_r != 9'h1ff);
	end
	sequence s_slot(x);
		x [*8];
	endsequence
	// Reset seen high, then released at the next bit clock edge
	sequence s_held_rst;
		sys_rst_in ##1 !sys_rst_in;
	endsequence
	property p_ind;
		@(posedge tx_bit_clock_in) disable iff (sys_rst_in)
		tx_slot_active_n_oe_out == |tx_slot_pulse_outputs_out && !tx_slot_active_n_out;
	endproperty
	a_ind: assert property (p_ind) else $error("indicator off");
	property p_tx_wid;
		@(negedge tx_bit_clock_in) disable iff (sys_rst_in)
		$rose(tx_slot_pulse_outputs_out[0]) |-> s_slot(tx_slot_pulse_outputs_out[0]);
	endproperty
	a_tx_wid: assert property (p_tx_wid) else $error("tx pulse short");
	property p_rx_wid;
		@(negedge rx_bit_clock_in) disable iff (sys_rst_in)
		$rose(rx_slot_pulse_outputs_out[0]) |-> s_slot(rx_slot_pulse_outputs_out[0]);
	endproperty
	a_rx_wid: assert property (p_rx_wid) else $error("rx pulse short");
	property p_tx_bound;
		@(negedge tx_bit_clock_in) disable iff (sys_rst_in)
		!$past(sys_rst_in) && tx_cnt_r[2:0] != 3'h0 |-> $stable(tx_slot_pulse_outputs_out);
	endproperty
	a_tx_bound: assert property (p_tx_bound) else $error("tx mid-slot edge");
	property p_rx_bound;
		@(negedge rx_bit_clock_in) disable iff (sys_rst_in)
		!$past(sys_rst_in) && rx_cnt_r[2:0] != 3'h0 |-> $stable(rx_slot_pulse_outputs_out);
	endproperty
	a_rx_bound: assert property (p_rx_bound) else $error("rx mid-slot edge");
	property p_tx_end;
		@(negedge tx_bit_clock_in) disable iff (sys_rst_in)
		tx_cnt_r[8] |-> tx_slot_pulse_outputs_out == 4'h0;
	endproperty
	a_tx_end: assert property (p_tx_end) else $error("tx pulse past end");
	property p_rx_end;
		@(negedge rx_bit_clock_in) disable iff (sys_rst_in)
		rx_cnt_r[8] |-> rx_slot_pulse_outputs_out == 4'h0;
	endproperty
	a_rx_end: assert property (p_rx_end) else $error("rx pulse past end");
	property p_tx_rst;
		@(negedge tx_bit_clock_in) s_held_rst |-> (tx_slot_pulse_outputs_out == 4'h0) [*8];
	endproperty
	a_tx_rst: assert property (p_tx_rst) else $error("pulse in reset");
endmodule : tsa_monitor
bind tsa_top tsa_monitor tsa_monitor_inst (.sys_rst_in, .tx_bit_clock_in,
	.rx_bit_clock_in, .tx_frame_start_in, .rx_frame_start_in, .tx_slot_pulse_outputs_out,
	.rx_slot_pulse_outputs_out, .tx_slot_active_n_out, .tx_slot_active_n_oe_out);

// *** bench/tsa_tb_top.sv ***
`timescale 1ns/10ps
module tsa_tb_top import tsa_pkg::*; ();
	logic       clock_in = 1'b0;
	logic       sys_rst_in = 1'b1;
	logic [1:0] bclk = 2'b00;
	logic [1:0] fs = 2'b00;
	logic [1:0] run = 2'b00;
	logic [5:0] len [2] = '{6'd32, 6'd32};
	tsa_slot_t  asg [2][4];
	logic [3:0] pls [2];
	logic       sclk, cs_n, dat, oe, drv, chk_en = 1'b0;
	logic [1:0] ch;
	int         error_cnt = 0;
	int         n_tests = 0;
	int         seed = 32'h7ea11764;
	always #2.5 clock_in = ~clock_in;
	always #6 bclk[0] = ~bclk[0];
	// Receive clock offset so the two links share no phase
	initial begin
		#3.7;
		forever #6 bclk[1] = ~bclk[1];
	end
	tsa_top tsa_top_inst (.clock_in, .sys_rst_in, .tx_bit_clock_in(bclk[0]),
		.rx_bit_clock_in(bclk[1]), .tx_frame_start_in(fs[0]), .rx_frame_start_in(fs[1]),
		.ctl_shift_clock_in(sclk), .ctl_select_n_in(cs_n), .ctl_serial_in(dat),
		.chan_sel_lsb_in(ch[0]), .chan_sel_msb_in(ch[1]), .tx_slot_active_n_in(oe ? drv : 1'b1),
		.tx_slot_pulse_outputs_out(pls[0]), .rx_slot_pulse_outputs_out(pls[1]),
		.tx_slot_active_n_out(drv), .tx_slot_active_n_oe_out(oe));
	tsa_ctl_model tsa_ctl_model_inst (.sclk_out(sclk), .cs_n_out(cs_n), .dat_out(dat), .ch_out(ch));
	function automatic logic f_exp(input logic [8:0] n, input tsa_slot_t a);
		return !a[5] && n[8:3] == a;
	endfunction : f_exp
	task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	for (genvar s = 0; s < 2; s++) begin : g_side
		logic [8:0] pos = 9'h0;
		logic [5:0] ln = 6'd32;
		logic [8:0] cnt = 9'h1ff;
		logic       fsq = 1'b0;
		logic [3:0] e;
		// Frame length only changes at a frame end, so slots stay whole
		always @(posedge bclk[s]) begin
			pos <= (pos + 9'h1 >= {ln, 3'h0}) ? 9'h0 : pos + 9'h1;
			if (pos + 9'h1 >= {ln, 3'h0})
				ln <= len[s];
			fs[s] <= run[s] && pos == 9'h0;
		end
		// Reference bit position, parked once a frame runs out
		always @(negedge bclk[s]) begin
			fsq <= fs[s];
			if (fs[s] && !fsq)
				cnt <= 9'h0;
			else if (cnt != 9'h1ff)
				cnt <= cnt + 9'h1;
		end
		// Pulses are settled half a bit clock after their launch edge
		always @(posedge bclk[s]) if (chk_en) begin
			for (int c = 0; c < 4; c++) e[c] = f_exp(cnt, asg[s][c]);
			check(s ? "rx_pulses" : "tx_pulses", {4'h0, pls[s]}, {4'h0, e});
			if (s == 0)
				check("tx_indicator", {6'h0, drv, oe}, {7'h0, |e});
		end
	end
	// A hang ends in the closing report
	initial begin
		#250000 error_cnt++;
		final_report();
	end
	// Main sequence: quiet power-up, then twelve words, three per direction code
	initial begin
		logic [1:0] c, d;
		tsa_slot_t  f;
		foreach (asg[s, k]) asg[s][k] = 6'h20;
		repeat (10) @(posedge clock_in);
		sys_rst_in <= 1'b0;
		run <= 2'b11;
		#3200 chk_en = 1'b1;
		#3200 $display("power-up quiet done");
		for (int k = 0; k < 12; k++) begin
			chk_en = 1'b0;
			c = (k < 4) ? k[1:0] : 2'($random(seed));
			d = k[1:0];
			f = (k == 0) ? 6'h00 : (k == 1) ? 6'h1f : 6'($random(seed));
			len[k[0]] = (k < 2) ? 6'd32 : 6'd8 + 6'($unsigned($random(seed)) % 25);
			// Words 6 and 9 are one bit short and one bit long; both must be dropped
			tsa_ctl_model_inst.load(c, {d, f}, (k == 6) ? 7 : (k == 9) ? 9 : 8);
			for (int s = 0; s < 2; s++) if (k != 6 && k != 9 && (d == 2'b11 || !d[1 - s]))
				asg[s][c] = (d == 2'b11) ? 6'h20 : f;
			#7000 chk_en = 1'b1;
			#7000 $display("word %0d ch %0d dir %0d slot %0d done", k, c, d, f);
		end
		run[0] <= 1'b0;
		#8000 $display("stopped frame done");
		final_report();
	end
endmodule : tsa_tb_top

// *** src/tsa_defines.svh ***
// Notes on behaviour
// R1 - A control word is two direction bits then a six-bit slot field, 0 to 31.
// R2 - Direction 00 both, 01 transmit only, 10 receive only, 11 disables both.
// R3 - A slot pulse is high for exactly eight bit clocks, else low.
// R4 - Frames hold up to 32 slots; slots past the frame end never pulse.
// R5 - Receive pulses follow receive frame start, transmit follow transmit, any phase.
// R6 - Two channel select inputs form channel 0 to 3 choosing the output pair.
// R7 - Transmit and receive slot counters run independently on their own clocks.
// R8 - After power-up all eight pulses stay low until an assignment is loaded.
// R9 - Controller holds channel select steady while a word is loaded.
// R10 - Control bits are sampled on falling control clock edges while select is low.
// R11 - Bits arrive transmit bit, receive bit, then field most significant first.
// R12 - Select rising copies the new field into the chosen channel registers.
// R13 - New assignments take effect at the first complete slot after select rises.
// R14 - Transmit counter clears on first falling edge after frame start, then counts per 8.
// R15 - Transmit count is compared with all four transmit assignments; matches pulse.
// R16 - Receive side behaves the same on its own clock and frame start.
// R17 - Open-drain slot indicator pulls low during any transmit pulse, else released.
// R18 - Field top bit set keeps the addressed output inactive.
// R19 - A counter not restarted stops past the last slot and never falsely matches.
`ifndef TSA_DEFINES_SVH
`define TSA_DEFINES_SVH

`define TSA_WORD_BITS    4'h8
`define TSA_BITS_OVER    4'h9
`define TSA_FIELD_W      6
`define TSA_OFF_BIT      5
`define TSA_SLOT_OFF     6'h20
`define TSA_SLOT_IDLE    6'h3f
`define TSA_SLOT_ZERO    6'h00
`define TSA_BIT_LAST     3'h7
`define TSA_ASSIGN_RESET 24'h820820

// Synchronised pin positions
`define TSA_PIN_CH0      0
`define TSA_PIN_CH1      1
`define TSA_PIN_DATA     2
`define TSA_PIN_SCLK     3
`define TSA_PIN_CS       4

`endif

// *** src/tsa_link_if.sv ***
`timescale 1ns/10ps
interface tsa_link_if;
	import tsa_pkg::*;
	tsa_assign_vec_t xfer;
	logic            req;
	logic            ack;
	logic [3:0]      pulse;

	modport sys  (output xfer, output req, input ack, input pulse);
	modport link (input xfer, input req, output ack, output pulse);
endinterface : tsa_link_if

// *** src/tsa_pkg.sv ***
package tsa_pkg;

	typedef logic [5:0]      tsa_slot_t;
	typedef logic [3:0][5:0] tsa_assign_vec_t;

	// Direction select codes, active low per side
	typedef enum logic [1:0] {
		TSA_DIR_BOTH = 2'b00,
		TSA_DIR_TX   = 2'b01,
		TSA_DIR_RX   = 2'b10,
		TSA_DIR_OFF  = 2'b11
	} tsa_dir_t;

endpackage : tsa_pkg

// *** src/tsa_slot_gen.sv ***
`timescale 1ns/10ps
`include "tsa_defines.svh"
module tsa_slot_gen import tsa_pkg::*; (
	input  wire logic bit_clock_in,   // Link bit clock
	input  wire logic frame_start_in, // Frame start, synchronous to bit clock
	input  wire logic sys_rst_in,     // System reset level, resynchronised here
	tsa_link_if.link  lnk             // Assignment transfer and pulses
);

	logic            rst_s1_r, rst_s2_r;
	logic            req_s1_r, req_s2_r, req_s3_r;
	logic            start_d_r, start_d_nxt;
	logic [2:0]      bit_r, bit_nxt;
	tsa_slot_t       slot_r, slot_nxt;
	tsa_assign_vec_t pend_r, pend_nxt;
	logic            pend_v_r, pend_v_nxt;
	tsa_assign_vec_t active_r, active_nxt;
	logic [3:0]      pulse_r, pulse_nxt;
	logic            frame_go;

	// Synchronisers for reset and the transfer toggle; first stages feed only second
	always_ff @(negedge bit_clock_in) begin
		rst_s1_r <= sys_rst_in;
		rst_s2_r <= rst_s1_r;
		req_s1_r <= lnk.req;
		req_s2_r <= req_s1_r;
		req_s3_r <= req_s2_r;
	end

	// Ack only after the word has been captured
	assign lnk.ack   = req_s3_r;
	assign lnk.pulse = pulse_r;
	assign frame_go  = frame_start_in & ~start_d_r;

	// Slot counting and compare, all on falling bit clock edges
	always_comb begin
		start_d_nxt = frame_start_in;
		bit_nxt     = bit_r + 3'h1;
		slot_nxt    = slot_r;
		pend_nxt    = pend_r;
		pend_v_nxt  = pend_v_r;
		active_nxt  = active_r;
		if (frame_go) begin
			bit_nxt  = 3'h0;                          // R14 R16 R5 R7
			slot_nxt = `TSA_SLOT_ZERO;                // R14 R16
		end else if (bit_r == `TSA_BIT_LAST) begin
			// Park at the idle code so a missing frame start cannot wrap into a match
			if (slot_r != `TSA_SLOT_IDLE) begin
				slot_nxt = slot_r + 6'h01;            // R19 R4
			end
		end
		// Applying only at a slot boundary keeps every pulse whole
		if ((bit_nxt == 3'h0) && pend_v_r) begin
			active_nxt = pend_r;                      // R13
			pend_v_nxt = 1'b0;
		end
		if (req_s2_r != req_s3_r) begin
			pend_nxt   = lnk.xfer;
			pend_v_nxt = 1'b1;
		end
		for (int i = 0; i < 4; i++) begin
			pulse_nxt[i] = ~active_nxt[i][`TSA_OFF_BIT] && (slot_nxt == active_nxt[i]); // R15 R18 R3
		end
	end

	always_ff @(negedge bit_clock_in) begin
		if (rst_s2_r) begin
			start_d_r <= 1'b1;
			bit_r     <= 3'h0;
			slot_r    <= `TSA_SLOT_IDLE;
			pend_r    <= `TSA_ASSIGN_RESET;
			pend_v_r  <= 1'b0;
			active_r  <= `TSA_ASSIGN_RESET;           // R8
			pulse_r   <= 4'h0;                        // R8
		end else begin
			start_d_r <= start_d_nxt;
			bit_r     <= bit_nxt;
			slot_r    <= slot_nxt;
			pend_r    <= pend_nxt;
			pend_v_r  <= pend_v_nxt;
			active_r  <= active_nxt;
			pulse_r   <= pulse_nxt;
		end
	end

endmodule : tsa_slot_gen

// *** src/tsa_top.sv ***
`timescale 1ns/10ps
`include "tsa_defines.svh"
module tsa_top import tsa_pkg::*; (
	input  wire logic       clock_in,                   // System clock, 200 MHz
	input  wire logic       sys_rst_in,                 // Synchronous reset, active high
	input  wire logic       tx_bit_clock_in,            // Transmit bit clock
	input  wire logic       rx_bit_clock_in,            // Receive bit clock
	input  wire logic       tx_frame_start_in,          // Transmit frame start
	input  wire logic       rx_frame_start_in,          // Receive frame start
	input  wire logic       ctl_shift_clock_in,         // Control shift clock pin
	input  wire logic       ctl_select_n_in,            // Control chip select, active low
	input  wire logic       ctl_serial_in,              // Control serial data pin
	input  wire logic       chan_sel_lsb_in,            // Channel select low bit
	input  wire logic       chan_sel_msb_in,            // Channel select high bit
	input  wire logic       tx_slot_active_n_in,        // Indicator wire level, unused
	output logic [3:0]      tx_slot_pulse_outputs_out,  // Transmit slot pulses
	output logic [3:0]      rx_slot_pulse_outputs_out,  // Receive slot pulses
	output logic            tx_slot_active_n_out,       // Indicator drive value
	output logic            tx_slot_active_n_oe_out     // Indicator drive enable
);

	logic [4:0]      pin_s1_r, pin_s2_r;
	logic [1:0]      edge_d_r;
	logic [7:0]      shift_r, shift_nxt;
	logic [3:0]      bits_r, bits_nxt;
	tsa_assign_vec_t assign_r [2];
	tsa_assign_vec_t assign_nxt [2];
	tsa_assign_vec_t xfer_r [2];
	tsa_assign_vec_t xfer_nxt [2];
	logic [1:0]      dirty_r, dirty_nxt;
	logic [1:0]      req_r, req_nxt;
	logic [1:0]      ack_s1_r, ack_s2_r;
	logic [1:0]      ack_w;
	logic [3:0]      pulse_w [2];
	logic            sclk_fall, cs_rise, cs_low;
	logic [1:0]      chan;
	tsa_dir_t        dir;
	tsa_slot_t       field;

	// Pin synchronisers; the control port is slow enough to oversample
	always_ff @(posedge clock_in) begin
		pin_s1_r <= {ctl_select_n_in, ctl_shift_clock_in, ctl_serial_in,
			chan_sel_msb_in, chan_sel_lsb_in};
		pin_s2_r <= pin_s1_r;
		edge_d_r <= {pin_s2_r[`TSA_PIN_CS], pin_s2_r[`TSA_PIN_SCLK]};
		ack_s1_r <= ack_w;
		ack_s2_r <= ack_s1_r;
	end

	// Edge detection reads only the second synchroniser stage
	assign cs_low    = ~pin_s2_r[`TSA_PIN_CS];
	assign sclk_fall = edge_d_r[0] & ~pin_s2_r[`TSA_PIN_SCLK];        // R10
	assign cs_rise   = ~edge_d_r[1] & pin_s2_r[`TSA_PIN_CS];          // R12
	assign chan      = {pin_s2_r[`TSA_PIN_CH1], pin_s2_r[`TSA_PIN_CH0]}; // R6 R9
	assign dir       = tsa_dir_t'(shift_r[7:6]);                      // R1 R11
	assign field     = shift_r[5:0];                                  // R1

	// Serial word capture, decode and launch of clock-domain transfers
	always_comb begin
		shift_nxt  = shift_r;
		bits_nxt   = bits_r;
		assign_nxt = assign_r;
		xfer_nxt   = xfer_r;
		dirty_nxt  = dirty_r;
		req_nxt    = req_r;
		if (!cs_low) begin
			bits_nxt = 4'h0;
		end else if (sclk_fall) begin
			shift_nxt = {shift_r[6:0], pin_s2_r[`TSA_PIN_DATA]};        // R10 R11
			if (bits_r != `TSA_BITS_OVER) begin
				bits_nxt = bits_r + 4'h1;
			end
		end
		// Launch only when the previous transfer is acknowledged
		for (int d = 0; d < 2; d++) begin
			if (dirty_r[d] && (req_r[d] == ack_s2_r[d])) begin
				xfer_nxt[d]  = assign_r[d];
				req_nxt[d]   = ~req_r[d];
				dirty_nxt[d] = 1'b0;
			end
		end
		// Short or long words are dropped rather than half applied
		if (cs_rise && (bits_r == `TSA_WORD_BITS)) begin
			case (dir)
				TSA_DIR_BOTH: begin
					assign_nxt[0][chan] = field;                 // R2 R12
					assign_nxt[1][chan] = field;                 // R2 R12
					dirty_nxt           = 2'b11;
				end
				TSA_DIR_TX: begin
					assign_nxt[0][chan] = field;                 // R2
					dirty_nxt[0]        = 1'b1;
				end
				TSA_DIR_RX: begin
					assign_nxt[1][chan] = field;                 // R2
					dirty_nxt[1]        = 1'b1;
				end
				default: begin
					assign_nxt[0][chan] = `TSA_SLOT_OFF;         // R2
					assign_nxt[1][chan] = `TSA_SLOT_OFF;         // R2
					dirty_nxt           = 2'b11;
				end
			endcase
		end
	end

	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			shift_r  <= 8'h00;
			bits_r   <= 4'h0;
			assign_r <= '{`TSA_ASSIGN_RESET, `TSA_ASSIGN_RESET}; // R8
			xfer_r   <= '{`TSA_ASSIGN_RESET, `TSA_ASSIGN_RESET};
			dirty_r  <= 2'b00;
			req_r    <= 2'b00;
		end else begin
			shift_r  <= shift_nxt;
			bits_r   <= bits_nxt;
			assign_r <= assign_nxt;
			xfer_r   <= xfer_nxt;
			dirty_r  <= dirty_nxt;
			req_r    <= req_nxt;
		end
	end

	// One slot generator per direction, each in its own bit clock domain
	generate
		for (genvar d = 0; d < 2; d++) begin : g_dir
			tsa_link_if lnk ();
			assign lnk.xfer  = xfer_r[d];
			assign lnk.req   = req_r[d];
			assign ack_w[d]  = lnk.ack;
			assign pulse_w[d] = lnk.pulse;
			tsa_slot_gen u_gen (
				.bit_clock_in   ((d == 0) ? tx_bit_clock_in : rx_bit_clock_in),     // R7
				.frame_start_in ((d == 0) ? tx_frame_start_in : rx_frame_start_in), // R5
				.sys_rst_in     (sys_rst_in),
				.lnk            (lnk.link)
			);
		end
	endgenerate

	assign tx_slot_pulse_outputs_out = pulse_w[0];
	assign rx_slot_pulse_outputs_out = pulse_w[1];                     // R16

	// Open-drain: only ever drive low, release otherwise
	assign tx_slot_active_n_out    = 1'b0;                             // R17
	assign tx_slot_active_n_oe_out = |pulse_w[0];                      // R17

endmodule : tsa_top
